// File: rtl/slf_cells.sv
// sampled emulation of the latch, flop and two-phase clock cells
// Function
// - latch follows data while gate high
// - driven latch makes its own gate complement
// - clearable latch forced low by clear
// - basic flop captures on true clock fall
// - flops hold value while clock stopped
// - clear forces q low, q_n high
// - preset/clear flop captures on rising edge
// - preset forces high, clear alone forces low (both together give q and q_n high)
`timescale 1ns/1ps
`default_nettype none
module slf_cells (
    input wire logic clk,            // system clock, 100 MHz
    input wire logic resetn,         // async reset, low active
    input wire logic lat_d,          // transparent latch data
    input wire logic lat_gate,       // transparent latch gate
    input wire logic lat_gate_n,     // transparent latch gate complement
    output logic lat_q,              // transparent latch true out
    output logic lat_q_n,            // transparent latch inverted out
    input wire logic dlat_d,         // driven latch data
    input wire logic dlat_gate,      // driven latch single gate
    output logic dlat_q,             // driven latch true out
    output logic dlat_q_n,           // driven latch inverted out
    input wire logic clat_clear_n,   // clearable latch clear, low active
    input wire logic clat_d,         // clearable latch data
    input wire logic clat_gate,      // clearable latch gate
    input wire logic clat_gate_n,    // clearable latch gate complement
    output logic clat_q,             // clearable latch true out
    output logic clat_q_n,           // clearable latch inverted out
    input wire logic bff_d,          // basic flop data
    input wire logic bff_cell_clock_true, // basic flop true clock
    input wire logic bff_cell_clock_n,    // basic flop clock complement
    output logic bff_q,              // basic flop out
    input wire logic cff_clear_n,    // clearable flop clear, low active
    input wire logic cff_d,          // clearable flop data
    input wire logic cff_cell_clock_true, // clearable flop true clock
    input wire logic cff_cell_clock_n,    // clearable flop clock complement
    output logic cff_q,              // clearable flop true out
    output logic cff_q_n,            // clearable flop inverted out
    input wire logic pcr_d,          // preset/clear flop data
    input wire logic pcr_clock,      // preset/clear flop single clock
    input wire logic pcr_preset_n,   // preset, low active
    input wire logic pcr_clear_n,    // clear, low active
    output logic pcr_q,              // preset/clear flop true out
    output logic pcr_q_n,            // preset/clear flop inverted out
    input wire logic tpd_in,         // two-phase driver input
    output logic phase_one_out,      // first phase, follows input
    output logic phase_two_out       // second phase, complement of input
);
    import slf_pkg::*;

    // ************************************************************
    // edge helpers
    // ************************************************************
    // falling edge between two sampled levels
    function automatic logic slf_fell(input logic prev, input logic now);
        return prev & ~now;
    endfunction : slf_fell

    // rising edge between two sampled levels
    function automatic logic slf_rose(input logic prev, input logic now);
        return ~prev & now;
    endfunction : slf_rose

    // ************************************************************
    // pin sampling
    // ************************************************************
    logic [SLF_NUM_IN-1:0] raw_in;  // all cell pins gathered
    logic [SLF_NUM_IN-1:0] s_in;    // filtered levels
    logic [SLF_NUM_IN-1:0] prev_ff; // levels one cycle earlier
    logic dlat_gate_n_int;          // generated gate complement

    assign raw_in[SLF_LAT_D] = lat_d;
    assign raw_in[SLF_LAT_G] = lat_gate;
    assign raw_in[SLF_LAT_GN] = lat_gate_n;
    assign raw_in[SLF_DLAT_D] = dlat_d;
    assign raw_in[SLF_DLAT_G] = dlat_gate;
    assign raw_in[SLF_CLAT_CN] = clat_clear_n;
    assign raw_in[SLF_CLAT_D] = clat_d;
    assign raw_in[SLF_CLAT_G] = clat_gate;
    assign raw_in[SLF_CLAT_GN] = clat_gate_n;
    assign raw_in[SLF_BFF_D] = bff_d;
    assign raw_in[SLF_BFF_CK] = bff_cell_clock_true;
    assign raw_in[SLF_BFF_CKN] = bff_cell_clock_n;
    assign raw_in[SLF_CFF_CN] = cff_clear_n;
    assign raw_in[SLF_CFF_D] = cff_d;
    assign raw_in[SLF_CFF_CK] = cff_cell_clock_true;
    assign raw_in[SLF_CFF_CKN] = cff_cell_clock_n;
    assign raw_in[SLF_PCR_D] = pcr_d;
    assign raw_in[SLF_PCR_CK] = pcr_clock;
    assign raw_in[SLF_PCR_PN] = pcr_preset_n;
    assign raw_in[SLF_PCR_CN] = pcr_clear_n;
    assign raw_in[SLF_TPD_IN] = tpd_in;

    // every pin is foreign to clk, so all pass the filter alike;
    // data and clock share one pipeline and keep their relation
    slf_sync #(
        .WIDTH(SLF_NUM_IN)
    ) slf_sync_i (
        .clk(clk),
        .resetn(resetn),
        .async_in(raw_in),
        .sync_out(s_in)
    );

    // previous levels for edge detection
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prev_ff <= '0;
        end else begin
            prev_ff <= s_in;
        end
    end

    // ************************************************************
    // transparent latch
    // ************************************************************
    logic lat_q_ff;  // stored level
    logic lat_qn_ff; // stored complement

    // open only while the gate pair reads high/low; else hold
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lat_q_ff <= SLF_RST_Q;
            lat_qn_ff <= SLF_RST_QN;
        end else if (s_in[SLF_LAT_G] && !s_in[SLF_LAT_GN]) begin
            lat_q_ff <= s_in[SLF_LAT_D];
            lat_qn_ff <= ~s_in[SLF_LAT_D];
        end
    end

    // ************************************************************
    // latch with its own clock driver
    // ************************************************************
    logic dlat_q_ff;  // stored level
    logic dlat_qn_ff; // stored complement

    // the complement phase is made here, so it cannot be misdriven
    assign dlat_gate_n_int = ~s_in[SLF_DLAT_G];

    // same behaviour as the plain latch
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dlat_q_ff <= SLF_RST_Q;
            dlat_qn_ff <= SLF_RST_QN;
        end else if (s_in[SLF_DLAT_G] && !dlat_gate_n_int) begin
            dlat_q_ff <= s_in[SLF_DLAT_D];
            dlat_qn_ff <= ~s_in[SLF_DLAT_D];
        end
    end

    // ************************************************************
    // clearable latch
    // ************************************************************
    logic clat_q_ff;  // stored level
    logic clat_qn_ff; // stored complement

    // clear overrides gate and data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clat_q_ff <= SLF_RST_Q;
            clat_qn_ff <= SLF_RST_QN;
        end else if (!s_in[SLF_CLAT_CN]) begin
            clat_q_ff <= SLF_RST_Q;
            clat_qn_ff <= SLF_RST_QN;
        end else if (s_in[SLF_CLAT_G] && !s_in[SLF_CLAT_GN]) begin
            clat_q_ff <= s_in[SLF_CLAT_D];
            clat_qn_ff <= ~s_in[SLF_CLAT_D];
        end
    end

    // ************************************************************
    // basic falling-edge flop
    // ************************************************************
    logic bff_q_ff; // stored level

    // only the true clock is watched; the complement pin is trusted
    // to mirror it, a broken pair is not detected
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bff_q_ff <= SLF_RST_Q;
        end else if (slf_fell(prev_ff[SLF_BFF_CK], s_in[SLF_BFF_CK])) begin
            bff_q_ff <= s_in[SLF_BFF_D];
        end
        // no edge: value kept for any length of stopped clock
    end

    // ************************************************************
    // clearable falling-edge flop
    // ************************************************************
    logic cff_q_ff;  // stored level
    logic cff_qn_ff; // stored complement

    // clear wins over any clock edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cff_q_ff <= SLF_RST_Q;
            cff_qn_ff <= SLF_RST_QN;
        end else if (!s_in[SLF_CFF_CN]) begin
            cff_q_ff <= SLF_RST_Q;
            cff_qn_ff <= SLF_RST_QN;
        end else if (slf_fell(prev_ff[SLF_CFF_CK], s_in[SLF_CFF_CK])) begin
            cff_q_ff <= s_in[SLF_CFF_D];
            cff_qn_ff <= ~s_in[SLF_CFF_D];
        end
        // stopped clock holds state
    end

    // ************************************************************
    // preset/clear rising-edge flop
    // ************************************************************
    logic pcr_q_ff;  // true output state
    logic pcr_qn_ff; // inverted output state

    // asynchronous controls beat the clock
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pcr_q_ff <= SLF_RST_Q;
            pcr_qn_ff <= SLF_RST_QN;
        end else begin
            case ({s_in[SLF_PCR_PN], s_in[SLF_PCR_CN]})
                2'b00: begin
                    pcr_q_ff <= 1'b1;
                    pcr_qn_ff <= 1'b1;
                end
                2'b01: begin
                    pcr_q_ff <= 1'b1;
                    pcr_qn_ff <= 1'b0;
                end
                2'b10: begin
                    pcr_q_ff <= 1'b0;
                    pcr_qn_ff <= 1'b1;
                end
                default: begin
                    if (slf_rose(prev_ff[SLF_PCR_CK], s_in[SLF_PCR_CK])) begin
                        pcr_q_ff <= s_in[SLF_PCR_D];
                        pcr_qn_ff <= ~s_in[SLF_PCR_D];
                    end else if (pcr_q_ff == pcr_qn_ff) begin
                        // leaving the both-high state with no edge:
                        // keep q, repair its complement
                        pcr_qn_ff <= ~pcr_q_ff;
                    end
                end
            endcase
        end
    end

    // ************************************************************
    // two-phase clock driver
    // ************************************************************
    logic p1_ff; // first phase
    logic p2_ff; // second phase

    // phases follow the input and its complement; which one goes to
    // the true clock pin picks the active edge of the driven cell
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            p1_ff <= SLF_RST_Q;
            p2_ff <= SLF_RST_QN;
        end else begin
            p1_ff <= s_in[SLF_TPD_IN];
            p2_ff <= ~s_in[SLF_TPD_IN];
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign lat_q = lat_q_ff;
    assign lat_q_n = lat_qn_ff;
    assign dlat_q = dlat_q_ff;
    assign dlat_q_n = dlat_qn_ff;
    assign clat_q = clat_q_ff;
    assign clat_q_n = clat_qn_ff;
    assign bff_q = bff_q_ff;
    assign cff_q = cff_q_ff;
    assign cff_q_n = cff_qn_ff;
    assign pcr_q = pcr_q_ff;
    assign pcr_q_n = pcr_qn_ff;
    assign phase_one_out = p1_ff;
    assign phase_two_out = p2_ff;

endmodule : slf_cells
`default_nettype wire

// File: rtl/slf_pkg.sv
// constants shared by the storage cell emulation block
package slf_pkg;

    // ************************************************************
    // synchroniser
    // ************************************************************
    localparam int SLF_SYNC_STAGES = 3; // shift stages ahead of the agreement flop

    // ************************************************************
    // reset values of stored levels
    // ************************************************************
    localparam logic SLF_RST_Q = 1'b0;  // true output after reset
    localparam logic SLF_RST_QN = 1'b1; // inverted output after reset

    // ************************************************************
    // bit positions in the sampled input vector
    // ************************************************************
    localparam int SLF_LAT_D = 0;   // transparent latch data
    localparam int SLF_LAT_G = 1;   // transparent latch gate
    localparam int SLF_LAT_GN = 2;  // transparent latch gate complement
    localparam int SLF_DLAT_D = 3;  // driven latch data
    localparam int SLF_DLAT_G = 4;  // driven latch gate
    localparam int SLF_CLAT_CN = 5; // clearable latch clear, low active
    localparam int SLF_CLAT_D = 6;  // clearable latch data
    localparam int SLF_CLAT_G = 7;  // clearable latch gate
    localparam int SLF_CLAT_GN = 8; // clearable latch gate complement
    localparam int SLF_BFF_D = 9;   // basic flop data
    localparam int SLF_BFF_CK = 10; // basic flop true clock
    localparam int SLF_BFF_CKN = 11; // basic flop clock complement
    localparam int SLF_CFF_CN = 12; // clearable flop clear, low active
    localparam int SLF_CFF_D = 13;  // clearable flop data
    localparam int SLF_CFF_CK = 14; // clearable flop true clock
    localparam int SLF_CFF_CKN = 15; // clearable flop clock complement
    localparam int SLF_PCR_D = 16;  // preset/clear flop data
    localparam int SLF_PCR_CK = 17; // preset/clear flop clock
    localparam int SLF_PCR_PN = 18; // preset/clear flop preset, low active
    localparam int SLF_PCR_CN = 19; // preset/clear flop clear, low active
    localparam int SLF_TPD_IN = 20; // two-phase driver input
    localparam int SLF_NUM_IN = 21; // width of the sampled vector

endpackage : slf_pkg

// File: rtl/slf_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module slf_sync #(
    parameter int WIDTH = 1 // number of pins
) (
    input wire logic clk,                 // system clock
    input wire logic resetn,              // async reset, low active
    input wire logic [WIDTH-1:0] async_in, // raw pins
    output logic [WIDTH-1:0] sync_out     // filtered, stable levels
);
    import slf_pkg::*;

    // ************************************************************
    // stage flops
    // ************************************************************
    logic [WIDTH-1:0] s1_ff; // metastable stage, read only by s2_ff
    logic [WIDTH-1:0] s2_ff; // second stage
    logic [WIDTH-1:0] s3_ff; // third stage
    logic [WIDTH-1:0] out_ff; // accepted level

    // shift chain; stage one feeds nothing but stage two
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            out_ff <= '0;
        end else begin
            out_ff <= (s2_ff & s3_ff) | (out_ff & (s2_ff | s3_ff));
        end
    end

    assign sync_out = out_ff;

endmodule : slf_sync
`default_nettype wire

// File: tb/slf_cells_sva.sv
// concurrent checks on the storage cell block ports
`timescale 1ns/1ps
`default_nettype none
module slf_cells_sva (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, low active
    input wire logic lat_d, // plain latch data
    input wire logic lat_gate, // plain latch gate
    input wire logic lat_gate_n, // plain latch gate complement
    input wire logic lat_q, // plain latch true out
    input wire logic lat_q_n, // plain latch inverted out
    input wire logic dlat_d, // driven latch data
    input wire logic dlat_gate, // driven latch gate
    input wire logic dlat_q, // driven latch true out
    input wire logic dlat_q_n, // driven latch inverted out
    input wire logic clat_clear_n, // clearable latch clear
    input wire logic clat_d, // clearable latch data
    input wire logic clat_gate, // clearable latch gate
    input wire logic clat_gate_n, // clearable latch gate complement
    input wire logic clat_q, // clearable latch true out
    input wire logic clat_q_n, // clearable latch inverted out
    input wire logic bff_d, // basic flop data
    input wire logic bff_cell_clock_true, // basic flop true clock
    input wire logic bff_cell_clock_n, // basic flop clock complement
    input wire logic bff_q, // basic flop out
    input wire logic cff_clear_n, // clearable flop clear
    input wire logic cff_d, // clearable flop data
    input wire logic cff_cell_clock_true, // clearable flop true clock
    input wire logic cff_cell_clock_n, // clearable flop clock complement
    input wire logic cff_q, // clearable flop true out
    input wire logic cff_q_n, // clearable flop inverted out
    input wire logic pcr_d, // preset/clear flop data
    input wire logic pcr_clock, // preset/clear flop clock
    input wire logic pcr_preset_n, // preset, low active
    input wire logic pcr_clear_n, // clear, low active
    input wire logic pcr_q, // preset/clear flop true out
    input wire logic pcr_q_n, // preset/clear flop inverted out
    input wire logic tpd_in, // two-phase driver input
    input wire logic phase_one_out, // first phase
    input wire logic phase_two_out // second phase
);
    // ************************************************************
    // common clocking
    // ************************************************************
    // windows of 8 samples cover the 5-edge pin latency plus margin
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    // ************************************************************
    // named steps of a flop capture
    // ************************************************************
    sequence bff_high_s; ($stable(bff_d) && bff_cell_clock_true)[*4]; endsequence
    sequence bff_low_s; ($stable(bff_d) && !bff_cell_clock_true)[*8]; endsequence
    sequence pcr_low_s; ($stable(pcr_d) && !pcr_clock && pcr_preset_n && pcr_clear_n)[*4]; endsequence
    sequence pcr_high_s; ($stable(pcr_d) && pcr_clock && pcr_preset_n && pcr_clear_n)[*8]; endsequence

    // ************************************************************
    // assertions
    // ************************************************************
    AST_LAT_FOLLOW: assert property (($stable(lat_d) && lat_gate && !lat_gate_n)[*8] |->
        lat_q == lat_d && lat_q_n != lat_d) else $error("latch does not follow data");
    AST_LAT_HOLD: assert property ((!lat_gate && lat_gate_n)[*8] |-> $stable(lat_q))
        else $error("closed latch output moved");
    AST_DLAT_FOLLOW: assert property (($stable(dlat_d) && dlat_gate)[*8] |->
        dlat_q == dlat_d && dlat_q_n != dlat_d) else $error("driven latch does not follow");
    AST_CLAT_CLEAR: assert property ((!clat_clear_n)[*8] |-> !clat_q && clat_q_n)
        else $error("latch clear ignored");
    AST_BFF_CAPTURE: assert property (bff_high_s ##1 bff_low_s |-> bff_q == bff_d)
        else $error("basic flop missed falling capture");
    AST_BFF_STATIC: assert property ($stable(bff_cell_clock_true)[*8] |-> $stable(bff_q))
        else $error("stopped flop lost value");
    AST_CFF_CLEAR: assert property ((!cff_clear_n)[*8] |-> !cff_q && cff_q_n)
        else $error("flop clear ignored");
    AST_PCR_CAPTURE: assert property (pcr_low_s ##1 pcr_high_s |-> pcr_q == pcr_d && pcr_q_n != pcr_d)
        else $error("rising flop missed capture");
    AST_PCR_PRESET: assert property ((!pcr_preset_n && pcr_clear_n)[*8] |-> pcr_q && !pcr_q_n)
        else $error("preset ignored");
    AST_PCR_CLEAR: assert property ((pcr_preset_n && !pcr_clear_n)[*8] |-> !pcr_q && pcr_q_n)
        else $error("clear ignored");
    AST_PCR_BOTH: assert property ((!pcr_preset_n && !pcr_clear_n)[*8] |-> pcr_q && pcr_q_n)
        else $error("preset with clear not both high");
    AST_TPD_PHASE: assert property ($stable(tpd_in)[*8] |->
        phase_one_out == tpd_in && phase_two_out != tpd_in) else $error("phase outputs wrong");
endmodule : slf_cells_sva
`default_nettype wire

// File: tb/slf_cells_tb.sv
// self-checking bench for the storage cell block
`timescale 1ns/1ps
`default_nettype none
module slf_cells_tb;
    import slf_pkg::*;
    // ************************************************************
    // stimulus and observed signals
    // ************************************************************
    logic clk, resetn; // bench clock and reset
    logic [SLF_NUM_IN-1:0] iv, prev, v; // applied, previous, staged pin vectors
    logic [6:0] st; // expected stored bits: lat dlat clat bff cff pcr_q pcr_q_n
    logic [31:0] r; // random generator state
    int fails, n_compared, cyc; // counters
    logic lat_q, lat_q_n, dlat_q, dlat_q_n, clat_q, clat_q_n, bff_q, cff_q, cff_q_n;
    logic pcr_q, pcr_q_n, phase_one_out, phase_two_out;

    slf_cells slf_cells_i (
        .clk(clk), .resetn(resetn),
        .lat_d(iv[SLF_LAT_D]), .lat_gate(iv[SLF_LAT_G]), .lat_gate_n(iv[SLF_LAT_GN]),
        .lat_q(lat_q), .lat_q_n(lat_q_n),
        .dlat_d(iv[SLF_DLAT_D]), .dlat_gate(iv[SLF_DLAT_G]), .dlat_q(dlat_q), .dlat_q_n(dlat_q_n),
        .clat_clear_n(iv[SLF_CLAT_CN]), .clat_d(iv[SLF_CLAT_D]), .clat_gate(iv[SLF_CLAT_G]),
        .clat_gate_n(iv[SLF_CLAT_GN]), .clat_q(clat_q), .clat_q_n(clat_q_n),
        .bff_d(iv[SLF_BFF_D]), .bff_cell_clock_true(iv[SLF_BFF_CK]), .bff_cell_clock_n(iv[SLF_BFF_CKN]),
        .bff_q(bff_q),
        .cff_clear_n(iv[SLF_CFF_CN]), .cff_d(iv[SLF_CFF_D]), .cff_cell_clock_true(iv[SLF_CFF_CK]),
        .cff_cell_clock_n(iv[SLF_CFF_CKN]), .cff_q(cff_q), .cff_q_n(cff_q_n),
        .pcr_d(iv[SLF_PCR_D]), .pcr_clock(iv[SLF_PCR_CK]), .pcr_preset_n(iv[SLF_PCR_PN]),
        .pcr_clear_n(iv[SLF_PCR_CN]), .pcr_q(pcr_q), .pcr_q_n(pcr_q_n),
        .tpd_in(iv[SLF_TPD_IN]), .phase_one_out(phase_one_out), .phase_two_out(phase_two_out)
    );

    // ************************************************************
    // expectation helpers
    // ************************************************************
    // next stored bits after the pins move from p to v in one held step
    function automatic logic [6:0] model(input logic [6:0] s, input logic [SLF_NUM_IN-1:0] p, vv);
        logic lq, dq, cq, bq, fq, pq, pqn;
        {lq, dq, cq, bq, fq, pq, pqn} = s;
        if (vv[SLF_LAT_G] && !vv[SLF_LAT_GN]) lq = vv[SLF_LAT_D];
        if (vv[SLF_DLAT_G]) dq = vv[SLF_DLAT_D];
        if (!vv[SLF_CLAT_CN]) cq = 1'b0;
        else if (vv[SLF_CLAT_G] && !vv[SLF_CLAT_GN]) cq = vv[SLF_CLAT_D];
        if (p[SLF_BFF_CK] && !vv[SLF_BFF_CK]) bq = vv[SLF_BFF_D];
        if (!vv[SLF_CFF_CN]) fq = 1'b0;
        else if (p[SLF_CFF_CK] && !vv[SLF_CFF_CK]) fq = vv[SLF_CFF_D];
        // low preset drives q high, low clear drives q_n high, both together give 1,1
        if (!vv[SLF_PCR_PN] || !vv[SLF_PCR_CN]) {pq, pqn} = {!vv[SLF_PCR_PN], !vv[SLF_PCR_CN]};
        else if (!p[SLF_PCR_CK] && vv[SLF_PCR_CK]) {pq, pqn} = {vv[SLF_PCR_D], !vv[SLF_PCR_D]};
        else pqn = !pq;
        return {lq, dq, cq, bq, fq, pq, pqn};
    endfunction : model

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_next

    // ************************************************************
    // checking and reporting
    // ************************************************************
    task automatic check(input logic [1:0] got, input logic [1:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic cmp_all();
        check({lat_q, lat_q_n}, {st[6], !st[6]});
        check({dlat_q, dlat_q_n}, {st[5], !st[5]});
        check({clat_q, clat_q_n}, {st[4], !st[4]});
        check({1'b0, bff_q}, {1'b0, st[3]});
        check({cff_q, cff_q_n}, {st[2], !st[2]});
        check({pcr_q, pcr_q_n}, st[1:0]);
        check({phase_one_out, phase_two_out}, {iv[SLF_TPD_IN], !iv[SLF_TPD_IN]});
    endtask : cmp_all

    task automatic print_verdict();
        if (fails == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // ************************************************************
    // stimulus tasks
    // ************************************************************
    // one held step at the falling edge; hold covers the 5-edge latency
    task automatic step(input logic [SLF_NUM_IN-1:0] w, input int hold);
        @(negedge clk);
        w[SLF_BFF_CKN] = !w[SLF_BFF_CK];
        w[SLF_CFF_CKN] = !w[SLF_CFF_CK];
        prev = iv;
        iv = w;
        st = model(st, prev, w);
        repeat (hold) @(negedge clk);
        cmp_all();
    endtask : step

    // random vector; data and async pins of a flop stay put when its clock moves
    task automatic rand_step();
        logic [SLF_NUM_IN-1:0] w;
        repeat (8) r = lfsr_next(r);
        w = r[SLF_NUM_IN-1:0];
        if (w[SLF_BFF_CK] != iv[SLF_BFF_CK]) w[SLF_BFF_D] = iv[SLF_BFF_D];
        if (w[SLF_CFF_CK] != iv[SLF_CFF_CK]) begin
            w[SLF_CFF_D] = iv[SLF_CFF_D];
            w[SLF_CFF_CN] = iv[SLF_CFF_CN];
        end
        if (w[SLF_PCR_CK] != iv[SLF_PCR_CK]) begin
            w[SLF_PCR_D] = iv[SLF_PCR_D];
            w[SLF_PCR_PN] = iv[SLF_PCR_PN];
            w[SLF_PCR_CN] = iv[SLF_PCR_CN];
        end
        step(w, 10);
    endtask : rand_step

    // ************************************************************
    // clock, timeout, main sequence
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ceiling well above the ~2300 cycles the sequence needs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            print_verdict();
        end
    end

    initial begin
        resetn = 1'b0;
        iv = '0;
        v = '0;
        st = 7'h01;
        r = 32'h0000005C; // seed 92
        fails = 0;
        n_compared = 0;
        cyc = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        cmp_all(); // reset levels
        resetn = 1'b1;
        step(v, 10); // preset and clear both low after release
        v[SLF_PCR_PN] = 1'b1; // leave both-low with no edge
        v[SLF_PCR_CN] = 1'b1;
        {v[SLF_LAT_G], v[SLF_LAT_D], v[SLF_DLAT_G], v[SLF_DLAT_D]} = 4'hF;
        {v[SLF_CLAT_CN], v[SLF_CLAT_G], v[SLF_CLAT_D]} = 3'h7;
        {v[SLF_BFF_CK], v[SLF_BFF_D], v[SLF_CFF_CN], v[SLF_CFF_CK], v[SLF_CFF_D]} = 5'h1F;
        v[SLF_TPD_IN] = 1'b1;
        step(v, 10);
        v[SLF_PCR_CK] = 1'b1; // rising edge captures 0
        {v[SLF_LAT_G], v[SLF_LAT_GN], v[SLF_LAT_D], v[SLF_DLAT_G], v[SLF_DLAT_D]} = 5'h08;
        {v[SLF_BFF_CK], v[SLF_CFF_CK], v[SLF_CLAT_CN]} = 3'h0;
        step(v, 10);
        v[SLF_PCR_D] = 1'b1;
        step(v, 10);
        v[SLF_PCR_CK] = 1'b0; // falling edge must not capture
        step(v, 10);
        v[SLF_PCR_CK] = 1'b1;
        v[SLF_CFF_CN] = 1'b0;
        step(v, 40); // pcr clock rises to capture 1 and cff clear goes low, then a long hold with clocks stopped
        repeat (100) rand_step();
        @(negedge clk);
        resetn = 1'b0; // mid-run reset, acts without a clock edge
        iv = '0; // idle pins so release shows no false edge
        st = 7'h01;
        @(negedge clk);
        cmp_all(); // reset levels again
        resetn = 1'b1;
        repeat (100) rand_step();
        print_verdict();
    end
endmodule : slf_cells_tb

bind slf_cells slf_cells_sva slf_cells_sva_i (.*);
`default_nettype wire
